// [amssw_pkg.sv]
package amssw_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int NCS = 4;
    localparam int CS_W = 2;
    localparam int ADDR_W = 22;
    localparam int BA_W = 2;
    localparam int WORD_W = 32;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int BEAT_W = 2;
    localparam int TA_W = 2;
    localparam int SETUP_W = 4;
    localparam int STROBE_W = 6;
    localparam int HOLD_W = 3;
    localparam int TMR_W = 6;

    // ----------------------------------------------------------------
    // Constants
    // ----------------------------------------------------------------
    localparam logic [BEAT_W-1:0] LAST_BEAT_NARROW = 2'h3;
    localparam logic [BEAT_W-1:0] LAST_BEAT_WIDE = 2'h1;
    localparam logic [BEAT_W-1:0] BEAT_FIRST = 2'h0;
    localparam logic [BEAT_W-1:0] BEAT_STEP = 2'h1;
    localparam logic [TA_W-1:0] TA_ZERO = 2'h0;
    localparam logic [TA_W-1:0] TA_STEP = 2'h1;
    localparam logic [TMR_W-1:0] TMR_ZERO = 6'h00;
    localparam logic [WORD_W-1:0] BYTE_MASK = 32'h0000_00ff;
    localparam logic RW_READ = 1'b1;
    localparam logic RW_WRITE = 1'b0;
    localparam logic STB_OFF = 1'b1;
    localparam logic STB_ON = 1'b0;
    localparam logic [NCS-1:0] CS_ALL_OFF = 4'hf;

    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_TURN = 5'h02,
        S_SETUP = 5'h04,
        S_STROBE = 5'h08,
        S_HOLD = 5'h10
    } amssw_state_t;

endpackage

// [amssw_timer.sv]
`timescale 1ns/10ps
module amssw_timer (
    input wire logic clk_in,                              // Clock
    input wire logic reset_in,                            // Sync reset
    input wire logic load_in,                             // Load count
    input wire logic [amssw_pkg::TMR_W-1:0] value_in,     // Cycles less one
    output logic done_out                                 // Last cycle
);
    import amssw_pkg::*;

    logic [TMR_W-1:0] cnt_q;

    // ----------------------------------------------------------------
    // Phase down counter
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            cnt_q <= TMR_ZERO;
        end else if (load_in) begin
            cnt_q <= value_in;
        end else if (cnt_q != TMR_ZERO) begin
            cnt_q <= cnt_q - 6'h01;
        end
    end

    assign done_out = (cnt_q == TMR_ZERO);

    chk_timer_countdown: assert property (@(posedge clk_in)
        disable iff (reset_in)
        (!load_in && cnt_q != TMR_ZERO) |=> cnt_q == $past(cnt_q) - 6'h01)
        else $error("phase counter failed to count down");

endmodule

// [amssw_write_seq.sv]
`timescale 1ns/10ps
module amssw_write_seq (
    input wire logic CLK_IN,                                   // 125 MHz clock
    input wire logic RESET_IN,                                 // Sync reset
    input wire logic REQ_VALID_IN,                             // Write request
    output logic REQ_READY_OUT,                                // Request taken
    input wire logic [amssw_pkg::CS_W-1:0] REQ_CS_IN,          // Chip select
    input wire logic [amssw_pkg::ADDR_W-1:0] REQ_ADDR_IN,      // Word address
    input wire logic [amssw_pkg::BA_W-1:0] REQ_BA_IN,          // Bank address
    input wire logic [amssw_pkg::WORD_W-1:0] REQ_DATA_IN,      // Write word
    input wire logic [amssw_pkg::NCS*amssw_pkg::TA_W-1:0]
        CFG_TURNAROUND_COUNT_IN,                               // Per CS
    input wire logic [amssw_pkg::NCS*amssw_pkg::SETUP_W-1:0]
        CFG_WSETUP_IN,                                         // Per CS
    input wire logic [amssw_pkg::NCS*amssw_pkg::STROBE_W-1:0]
        CFG_WSTROBE_IN,                                        // Per CS
    input wire logic [amssw_pkg::NCS*amssw_pkg::HOLD_W-1:0]
        CFG_WHOLD_IN,                                          // Per CS
    input wire logic [amssw_pkg::NCS-1:0] CFG_WIDE_IN,         // 1: 16-bit
    output logic [amssw_pkg::NCS-1:0] CHIP_SELECT_STROBE_N_OUT, // Per CS
    output logic WRITE_STROBE_N_OUT,                           // Write strobe
    output logic OUTPUT_ENABLE_STROBE_N_OUT,                   // Held high
    output logic READ_WRITE_INDICATOR_OUT,                     // Low: write
    output logic [amssw_pkg::ADDR_W-1:0] EXT_ADDRESS_BUS_OUT,  // Address
    output logic [amssw_pkg::BA_W-1:0] BANK_ADDRESS_LINES_OUT, // Bank
    output logic [amssw_pkg::DATA_W-1:0] EXT_DATA_BUS_OUT,     // Data out
    output logic EXT_DATA_BUS_OE_OUT,                          // Data enable
    output logic BUSY_OUT                                      // Not idle
);
    import amssw_pkg::*;

    // ----------------------------------------------------------------
    // Decoding helpers
    // ----------------------------------------------------------------
    function automatic logic f_last(input logic [BEAT_W-1:0] b,
                                    input logic wide);
        return b == (wide ? LAST_BEAT_WIDE : LAST_BEAT_NARROW);
    endfunction

    function automatic logic [DATA_W-1:0] f_slice(
        input logic [WORD_W-1:0] w, input logic [BEAT_W-1:0] b,
        input logic wide);
        logic [WORD_W-1:0] s;
        s = wide ? (w >> (b * DATA_W)) : ((w >> (b * BYTE_W)) & BYTE_MASK);
        return s[DATA_W-1:0];
    endfunction

    function automatic logic [TMR_W-1:0] f_ta(input logic [CS_W-1:0] cs,
        input logic [NCS*TA_W-1:0] cfg);
        logic [TA_W-1:0] ta;
        ta = cfg[cs*TA_W +: TA_W];
        return (ta == TA_ZERO) ? TMR_ZERO : TMR_W'(ta - TA_STEP);
    endfunction

    amssw_state_t state_q, state_d;
    logic pend_q, pend_d, accept, pend_now, tmr_done, tmr_load;
    logic go_first, go_new, go_beat, from_turn, last_now, same_cs;
    logic [TMR_W-1:0] tmr_val;
    logic [CS_W-1:0] req_cs_q, cur_cs_q, src_cs, new_cs;
    logic [ADDR_W-1:0] req_addr_q, cur_addr_q, src_addr;
    logic [BA_W-1:0] req_ba_q, cur_ba_q, src_ba;
    logic [WORD_W-1:0] req_data_q, cur_data_q, src_data;
    logic [BEAT_W-1:0] beat_q;
    logic wide_q;
    logic [SETUP_W-1:0] setup_q, new_setup;
    logic [STROBE_W-1:0] strobe_q;
    logic [HOLD_W-1:0] hold_q;

    assign accept = REQ_VALID_IN && REQ_READY_OUT;
    assign pend_now = pend_q || accept;
    assign src_cs = pend_q ? req_cs_q : REQ_CS_IN;
    assign src_addr = pend_q ? req_addr_q : REQ_ADDR_IN;
    assign src_ba = pend_q ? req_ba_q : REQ_BA_IN;
    assign src_data = pend_q ? req_data_q : REQ_DATA_IN;
    assign from_turn = (state_q == S_TURN);
    assign new_cs = from_turn ? cur_cs_q : src_cs;
    assign new_setup = CFG_WSETUP_IN[new_cs*SETUP_W +: SETUP_W];
    assign last_now = f_last(beat_q, wide_q);
    assign same_cs = (src_cs == cur_cs_q);

    // ----------------------------------------------------------------
    // Phase sequencing
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        tmr_val = TMR_ZERO;
        go_first = 1'b0;
        go_new = 1'b0;
        go_beat = 1'b0;
        unique case (state_q)
            S_IDLE: begin
                if (accept) begin
                    state_d = S_TURN;
                    go_first = 1'b1;
                    tmr_val = f_ta(src_cs, CFG_TURNAROUND_COUNT_IN);
                end
            end
            S_TURN: begin
                if (tmr_done) begin
                    state_d = S_SETUP;
                    go_new = 1'b1;
                    tmr_val = TMR_W'(new_setup);
                end
            end
            S_SETUP: begin
                if (tmr_done) begin
                    state_d = S_STROBE;
                    tmr_val = TMR_W'(strobe_q);
                end
            end
            S_STROBE: begin
                if (tmr_done) begin
                    state_d = S_HOLD;
                    tmr_val = TMR_W'(hold_q);
                end
            end
            S_HOLD: begin
                if (tmr_done) begin
                    if (!last_now) begin
                        state_d = S_SETUP;
                        go_beat = 1'b1;
                        tmr_val = TMR_W'(setup_q);
                    end else if (pend_now) begin
                        go_first = 1'b1;
                        if (same_cs) begin
                            state_d = S_SETUP;
                            go_new = 1'b1;
                            tmr_val = TMR_W'(new_setup);
                        end else begin
                            state_d = S_TURN;
                            tmr_val = f_ta(src_cs, CFG_TURNAROUND_COUNT_IN);
                        end
                    end else begin
                        state_d = S_IDLE;
                    end
                end
            end
        endcase
        tmr_load = (state_d != state_q);
    end

    assign pend_d = pend_now && !go_first;

    amssw_timer u_timer (
        .clk_in(CLK_IN),
        .reset_in(RESET_IN),
        .load_in(tmr_load),
        .value_in(tmr_val),
        .done_out(tmr_done)
    );

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            state_q <= S_IDLE;
            pend_q <= 1'b0;
            REQ_READY_OUT <= 1'b0;
            BUSY_OUT <= 1'b0;
        end else begin
            state_q <= state_d;
            pend_q <= pend_d;
            REQ_READY_OUT <= !pend_d && (state_d == S_IDLE
                || (state_d == S_HOLD && last_now));
            BUSY_OUT <= (state_d != S_IDLE);
        end
    end

    // ----------------------------------------------------------------
    // Request and beat holding
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_IN) begin
        if (accept) begin
            req_cs_q <= REQ_CS_IN;
            req_addr_q <= REQ_ADDR_IN;
            req_ba_q <= REQ_BA_IN;
            req_data_q <= REQ_DATA_IN;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            cur_cs_q <= '0;
            cur_addr_q <= '0;
            cur_ba_q <= '0;
            cur_data_q <= '0;
            beat_q <= BEAT_FIRST;
            wide_q <= 1'b0;
        end else if (go_first) begin
            cur_cs_q <= src_cs;
            cur_addr_q <= src_addr;
            cur_ba_q <= src_ba;
            cur_data_q <= src_data;
            beat_q <= BEAT_FIRST;
            wide_q <= CFG_WIDE_IN[src_cs];
        end else if (go_beat) begin
            beat_q <= beat_q + BEAT_STEP;
        end
    end

    // Timing is latched once per request; later beats reuse it
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            setup_q <= '0;
            strobe_q <= '0;
            hold_q <= '0;
        end else if (go_new) begin
            setup_q <= new_setup;
            strobe_q <= CFG_WSTROBE_IN[new_cs*STROBE_W +: STROBE_W];
            hold_q <= CFG_WHOLD_IN[new_cs*HOLD_W +: HOLD_W];
        end
    end

    // ----------------------------------------------------------------
    // Memory pins
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            EXT_ADDRESS_BUS_OUT <= '0;
            BANK_ADDRESS_LINES_OUT <= '0;
            EXT_DATA_BUS_OUT <= '0;
            EXT_DATA_BUS_OE_OUT <= 1'b0;
            READ_WRITE_INDICATOR_OUT <= RW_READ;
        end else if (go_beat) begin
            EXT_ADDRESS_BUS_OUT <= cur_addr_q + ADDR_W'(beat_q + BEAT_STEP);
            EXT_DATA_BUS_OUT <= f_slice(cur_data_q, beat_q + BEAT_STEP,
                                        wide_q);
            EXT_DATA_BUS_OE_OUT <= 1'b1;
        end else if (go_new) begin
            EXT_ADDRESS_BUS_OUT <= from_turn ? cur_addr_q : src_addr;
            BANK_ADDRESS_LINES_OUT <= from_turn ? cur_ba_q : src_ba;
            EXT_DATA_BUS_OUT <= from_turn
                ? f_slice(cur_data_q, BEAT_FIRST, wide_q)
                : f_slice(src_data, BEAT_FIRST, CFG_WIDE_IN[src_cs]);
            EXT_DATA_BUS_OE_OUT <= 1'b1;
            READ_WRITE_INDICATOR_OUT <= RW_WRITE;
        end else if (state_q == S_HOLD && tmr_done) begin
            EXT_DATA_BUS_OE_OUT <= 1'b0;
            READ_WRITE_INDICATOR_OUT <= RW_READ;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            CHIP_SELECT_STROBE_N_OUT <= CS_ALL_OFF;
            WRITE_STROBE_N_OUT <= STB_OFF;
            OUTPUT_ENABLE_STROBE_N_OUT <= STB_OFF;
        end else begin
            OUTPUT_ENABLE_STROBE_N_OUT <= STB_OFF;
            if (state_q == S_SETUP && tmr_done) begin
                CHIP_SELECT_STROBE_N_OUT[cur_cs_q] <= STB_ON;
                WRITE_STROBE_N_OUT <= STB_ON;
            end else if (state_q == S_STROBE && tmr_done) begin
                CHIP_SELECT_STROBE_N_OUT <= CS_ALL_OFF;
                WRITE_STROBE_N_OUT <= STB_OFF;
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RESET_IN);

    logic [TMR_W:0] ph_cnt_q;
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN || state_d != state_q) begin
            ph_cnt_q <= '0;
        end else begin
            ph_cnt_q <= ph_cnt_q + 7'h01;
        end
    end

    chk_oe_held_high: assert property (OUTPUT_ENABLE_STROBE_N_OUT)
        else $error("output enable strobe went low");
    chk_turn_to_setup: assert property ((state_q == S_TURN && tmr_done)
        |=> state_q == S_SETUP && EXT_DATA_BUS_OE_OUT)
        else $error("turnaround did not lead to setup");
    chk_same_cs_skip: assert property ((state_q == S_HOLD && tmr_done
        && last_now && pend_now && same_cs) |=> state_q == S_SETUP)
        else $error("turnaround inserted between same-select writes");
    chk_ta_zero_one: assert property ((state_q == S_IDLE && accept
        && CFG_TURNAROUND_COUNT_IN[REQ_CS_IN*TA_W +: TA_W] == TA_ZERO)
        |=> state_q == S_TURN ##1 state_q == S_SETUP)
        else $error("zero turnaround not one cycle");
    chk_setup_length: assert property ((state_q == S_SETUP
        && state_d != S_SETUP) |-> ph_cnt_q == 7'(setup_q))
        else $error("setup length differs from latched value");
    chk_strobe_length: assert property ((state_q == S_STROBE
        && state_d != S_STROBE) |-> ph_cnt_q == 7'(strobe_q))
        else $error("strobe length differs from latched value");
    chk_setup_drive: assert property ($rose(state_q == S_SETUP)
        |-> EXT_DATA_BUS_OE_OUT && READ_WRITE_INDICATOR_OUT == RW_WRITE)
        else $error("bus not driven as write at setup");
    chk_strobe_pair: assert property ((state_q == S_STROBE)
        == (!WRITE_STROBE_N_OUT && CHIP_SELECT_STROBE_N_OUT != CS_ALL_OFF))
        else $error("strobes out of step with strobe phase");
    chk_hold_release: assert property (state_q == S_HOLD |->
        WRITE_STROBE_N_OUT && CHIP_SELECT_STROBE_N_OUT == CS_ALL_OFF)
        else $error("strobes low during hold");
    chk_idle_released: assert property ((state_q == S_IDLE
        || state_q == S_TURN) |-> !EXT_DATA_BUS_OE_OUT
        && READ_WRITE_INDICATOR_OUT == RW_READ)
        else $error("bus still driven outside an access");
    chk_next_beat: assert property ((state_q == S_HOLD && tmr_done
        && !last_now) |=> state_q == S_SETUP && $stable(setup_q))
        else $error("next beat did not restart setup");

    cov_single_write: cover property (state_q == S_HOLD ##1 state_q == S_IDLE);
    cov_narrow_beats: cover property (go_beat && beat_q == BEAT_STEP);
    cov_back_to_back: cover property (state_q == S_HOLD && go_new);

endmodule

// [amssw_mem_model.sv]
`timescale 1ns/10ps
module amssw_mem_model (
    input wire logic clk_in,                          // Clock
    input wire logic rst_in,                          // Sync reset
    input wire logic [amssw_pkg::NCS-1:0] cs_n_in,    // Chip selects
    input wire logic we_n_in,                         // Write strobe
    input wire logic oe_n_in,                         // Output enable
    input wire logic rw_in,                           // Low: write
    input wire logic [amssw_pkg::ADDR_W-1:0] addr_in, // Address
    input wire logic [amssw_pkg::DATA_W-1:0] data_in, // Data
    input wire logic data_oe_in                       // Data enable
);
    import amssw_pkg::*;
    logic we_n_q = 1'b1;
    logic [NCS-1:0] cs_n_q = 4'hf;
    logic [ADDR_W-1:0] addr_q[$];
    logic [DATA_W-1:0] data_q[$];
    logic [NCS-1:0] sel_q[$];
    int bad = 0;

    // ----------------------------------------------------------------
    // Pin watch and write capture
    // ----------------------------------------------------------------
    always @(posedge clk_in) begin
        if (!rst_in) begin
            if (oe_n_in !== 1'b1) bad++;
            if ((cs_n_in === 4'hf) !== (we_n_in === 1'b1)) bad++;
            if (we_n_in === 1'b0 && (rw_in !== 1'b0 || data_oe_in !== 1'b1))
                bad++;
            // The memory latches on the rising write strobe
            if (we_n_q === 1'b0 && we_n_in === 1'b1) begin
                addr_q.push_back(addr_in);
                data_q.push_back(data_in);
                sel_q.push_back(cs_n_q);
            end
        end
        we_n_q <= we_n_in;
        cs_n_q <= cs_n_in;
    end
endmodule

// [tb.sv]
`timescale 1ns/10ps
module tb;
    import amssw_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic req_ready;
    logic [CS_W-1:0] req_cs = 2'h0;
    logic [ADDR_W-1:0] req_addr = 22'h000000;
    logic [BA_W-1:0] req_ba = 2'h2;
    logic [WORD_W-1:0] req_data = 32'h00000000;
    logic [NCS*TA_W-1:0] cfg_ta = 8'h00;
    logic [NCS*SETUP_W-1:0] cfg_su = 16'h0000;
    logic [NCS*STROBE_W-1:0] cfg_st = 24'h000000;
    logic [NCS*HOLD_W-1:0] cfg_ho = 12'h000;
    logic [NCS-1:0] cfg_wide = 4'h0;
    logic [NCS-1:0] cs_n;
    logic we_n, oe_n, rw, data_oe, busy;
    logic [ADDR_W-1:0] addr;
    logic [BA_W-1:0] ba;
    logic [DATA_W-1:0] data;
    int failures = 0;
    int comparisons = 0;
    int cyc = 0;
    int take_q[$], fall_q[$], rise_q[$];
    logic we_q = 1'b1;

    amssw_write_seq amssw_write_seq_inst (.CLK_IN(clk), .RESET_IN(rst),
        .REQ_VALID_IN(req_valid), .REQ_READY_OUT(req_ready),
        .REQ_CS_IN(req_cs), .REQ_ADDR_IN(req_addr), .REQ_BA_IN(req_ba),
        .REQ_DATA_IN(req_data), .CFG_TURNAROUND_COUNT_IN(cfg_ta),
        .CFG_WSETUP_IN(cfg_su), .CFG_WSTROBE_IN(cfg_st),
        .CFG_WHOLD_IN(cfg_ho), .CFG_WIDE_IN(cfg_wide),
        .CHIP_SELECT_STROBE_N_OUT(cs_n), .WRITE_STROBE_N_OUT(we_n),
        .OUTPUT_ENABLE_STROBE_N_OUT(oe_n), .READ_WRITE_INDICATOR_OUT(rw),
        .EXT_ADDRESS_BUS_OUT(addr), .BANK_ADDRESS_LINES_OUT(ba),
        .EXT_DATA_BUS_OUT(data), .EXT_DATA_BUS_OE_OUT(data_oe),
        .BUSY_OUT(busy));

    amssw_mem_model amssw_mem_model_inst (.clk_in(clk), .rst_in(rst),
        .cs_n_in(cs_n), .we_n_in(we_n), .oe_n_in(oe_n), .rw_in(rw),
        .addr_in(addr), .data_in(data), .data_oe_in(data_oe));

    always #4 clk = ~clk;

    // ----------------------------------------------------------------
    // Edge log: takes, strobe falls and rises by cycle number
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (req_valid === 1'b1 && req_ready === 1'b1) take_q.push_back(cyc);
        if (we_q === 1'b1 && we_n === 1'b0) fall_q.push_back(cyc);
        if (we_q === 1'b0 && we_n === 1'b1) rise_q.push_back(cyc);
        we_q = we_n;
        cyc++;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d, failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic set_cs(input int c, ta, su, st, ho, input logic wide);
        cfg_ta[c*TA_W +: TA_W] = TA_W'(ta);
        cfg_su[c*SETUP_W +: SETUP_W] = SETUP_W'(su);
        cfg_st[c*STROBE_W +: STROBE_W] = STROBE_W'(st);
        cfg_ho[c*HOLD_W +: HOLD_W] = HOLD_W'(ho);
        cfg_wide[c] = wide;
        take_q.delete();
        fall_q.delete();
        rise_q.delete();
        amssw_mem_model_inst.addr_q.delete();
        amssw_mem_model_inst.data_q.delete();
        amssw_mem_model_inst.sel_q.delete();
    endtask

    // Holds the request until it is taken; valid is left high
    task automatic send(input int c, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        req_valid = 1'b1;
        req_cs = CS_W'(c);
        req_addr = a[ADDR_W-1:0];
        req_data = d;
        while (req_ready !== 1'b1 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 200) failures++;
        @(posedge clk);
        #1;
    endtask

    task automatic drop_wait();
        int n;
        n = 0;
        req_valid = 1'b0;
        while (busy !== 1'b0 && n < 500) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 500) failures++;
        check(rw, 1'b1);
        check(data_oe, 1'b0);
        check(ba, req_ba);
        check(amssw_mem_model_inst.bad, 0);
    endtask

    task automatic beats(input int n, su, st, ho);
        check(fall_q.size(), n);
        for (int i = 0; i < n; i++) begin
            check(rise_q[i] - fall_q[i], st + 1);
            if (i > 0) check(fall_q[i] - rise_q[i-1], ho + su + 2);
        end
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_narrow();
        set_cs(0, 2, 1, 2, 1, 1'b0);
        send(0, 32'h001230, 32'h44332211);
        drop_wait();
        check(fall_q[0] - take_q[0], 2 + 2 + 1);
        beats(4, 1, 2, 1);
        for (int i = 0; i < 4; i++) begin
            check(amssw_mem_model_inst.addr_q[i], 32'h1230 + i);
            check(amssw_mem_model_inst.data_q[i], 32'h44332211 >> (8*i) & BYTE_MASK);
            check(amssw_mem_model_inst.sel_q[i], 4'he);
        end
        $display("test narrow done");
    endtask

    task automatic t_wide_ta0();
        set_cs(2, 0, 0, 0, 0, 1'b1);
        send(2, 32'h3ffffe, 32'hbeefcafe);
        drop_wait();
        check(fall_q[0] - take_q[0], 1 + 1 + 1);
        beats(2, 0, 0, 0);
        check(amssw_mem_model_inst.data_q[0], 32'hcafe);
        check(amssw_mem_model_inst.data_q[1], 32'hbeef);
        check(amssw_mem_model_inst.addr_q[1], 32'h3fffff);
        check(amssw_mem_model_inst.sel_q[1], 4'hb);
        $display("test wide done");
    endtask

    task automatic t_back_to_back();
        set_cs(3, 1, 0, 0, 0, 1'b1);
        set_cs(1, 3, 2, 1, 2, 1'b1);
        send(1, 32'h000100, 32'h22221111);
        send(1, 32'h000200, 32'h44443333);
        send(3, 32'h000300, 32'h66665555);
        drop_wait();
        check(fall_q.size(), 6);
        check(fall_q[0] - take_q[0], 3 + 3 + 1);
        check(fall_q[1] - rise_q[0], 3 + 3);
        check(fall_q[2] - rise_q[1], 3 + 3);
        check(fall_q[4] - rise_q[3], 3 + 1 + 1);
        check(rise_q[4] - fall_q[4], 1);
        check(amssw_mem_model_inst.data_q[3], 32'h4444);
        check(amssw_mem_model_inst.sel_q[4], 4'h7);
        $display("test back to back done");
    endtask

    initial begin
        #200000;
        failures++;
        test_done();
    end

    initial begin
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        @(posedge clk);
        #1;
        t_narrow();
        t_wide_ta0();
        t_back_to_back();
        test_done();
    end
endmodule
